/* File: panel_bus_master.sv */
// How it works
// - Status read: select low, command low, fetch low.
// - Index write: command low, store strobe pulsed.
// - Memory read: command high, fetch pulsed.
// - Data write: command high, store pulsed.
// - One 16-bit bidirectional bus carries everything.
// - Init pulse driven low then released.
// - Store strobe low while write data driven.
// - Fetch strobe low while panel data sampled.
// - Write strobe low and high 50 ns each.
// - Read strobe low and high 150 ns each.
// - Output enables the external high-voltage supply.
// - Supply enable high means converter on.
`timescale 1ns/1ps
`default_nettype none

module panel_bus_master
#(
  parameter int INIT_CYC = panel_bus_pkg::INIT_LOW_CYC
)
(
  input  wire logic                             i_clk,
  input  wire logic                             i_rst_n,
  input  wire logic                             i_req_valid,
  input  wire panel_bus_pkg::req_t              i_req,
  output logic                                  o_req_ready,
  output logic                                  o_rd_valid,
  output logic [panel_bus_pkg::BUS_W-1:0]       o_rd_data,
  input  wire logic                             i_init_start,
  input  wire logic                             i_hv_supply_req,
  output logic                                  o_init_busy,
  output logic                                  o_hv_supply_on,
  output logic                                  o_panel_init_pulse_n,
  output panel_bus_pkg::ctl_t                   o_ctl,
  output logic [panel_bus_pkg::BUS_W-1:0]       o_panel_bus,
  output logic                                  o_panel_bus_oe,
  input  wire logic [panel_bus_pkg::BUS_W-1:0]  i_panel_bus
);

  // ---------------------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------------------
  if (INIT_CYC < 1 || INIT_CYC > 4095)
  begin : g_bad_init
    $error("INIT_CYC out of range");
  end

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_INIT,
    ST_SETUP,
    ST_LOW,
    ST_HIGH
  } state_t;

  localparam logic [panel_bus_pkg::CNT_W-1:0] WL   = panel_bus_pkg::CNT_W'(panel_bus_pkg::WR_LOW_CYC);
  localparam logic [panel_bus_pkg::CNT_W-1:0] WH   = panel_bus_pkg::CNT_W'(panel_bus_pkg::WR_HIGH_CYC);
  localparam logic [panel_bus_pkg::CNT_W-1:0] RL   = panel_bus_pkg::CNT_W'(panel_bus_pkg::RD_LOW_CYC);
  localparam logic [panel_bus_pkg::CNT_W-1:0] RH   = panel_bus_pkg::CNT_W'(panel_bus_pkg::RD_HIGH_CYC);
  localparam logic [panel_bus_pkg::CNT_W-1:0] SU   = panel_bus_pkg::CNT_W'(panel_bus_pkg::SETUP_CYC);
  localparam logic [panel_bus_pkg::CNT_W-1:0] INIT = panel_bus_pkg::CNT_W'(INIT_CYC);

  // ---------------------------------------------------------------------------
  // Input synchroniser for the panel-driven bus
  // ---------------------------------------------------------------------------
  logic [panel_bus_pkg::BUS_W-1:0] bus_in;

  sync3 #(.W(panel_bus_pkg::BUS_W)) u_sync
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_panel_bus),
    .o_sync  (bus_in)
  );

  // ---------------------------------------------------------------------------
  // Transfer sequencer
  // ---------------------------------------------------------------------------
  state_t                          state;
  state_t                          next_state;
  logic [panel_bus_pkg::CNT_W-1:0] cnt;
  logic [panel_bus_pkg::CNT_W-1:0] next_cnt;
  panel_bus_pkg::op_t              op;
  panel_bus_pkg::op_t              next_op;
  logic [panel_bus_pkg::BUS_W-1:0] wdata;
  logic [panel_bus_pkg::BUS_W-1:0] next_wdata;
  panel_bus_pkg::ctl_t             next_ctl;
  logic                            next_oe;
  logic                            next_init_n;
  logic                            next_ready;
  logic                            next_rd_valid;
  logic [panel_bus_pkg::BUS_W-1:0] next_rd_data;
  logic                            is_wr;
  logic                            is_rd;

  assign is_wr = (op == panel_bus_pkg::OP_WRITE_INDEX) || (op == panel_bus_pkg::OP_WRITE_DATA);
  assign is_rd = !is_wr;

  always_comb
  begin
    next_state    = state;
    next_cnt      = cnt;
    next_op       = op;
    next_wdata    = wdata;
    next_ctl      = o_ctl;
    next_oe       = o_panel_bus_oe;
    next_init_n   = o_panel_init_pulse_n;
    next_ready    = 1'b0;
    next_rd_valid = 1'b0;
    next_rd_data  = o_rd_data;
    case (state)
      ST_IDLE:
      begin
        next_ctl.sel_n   = 1'b1;
        next_ctl.fetch_n = 1'b1;
        next_ctl.store_n = 1'b1;
        next_oe          = 1'b0;
        if (i_init_start)
        begin
          next_init_n = 1'b0;
          next_cnt    = INIT;
          next_state  = ST_INIT;
        end
        else if (i_req_valid && o_req_ready)
        begin
          next_op    = i_req.op;
          next_wdata = i_req.wdata;
          // Command select low addresses index/status, high addresses data.
          next_ctl.cmd_data_sel = (i_req.op == panel_bus_pkg::OP_READ_MEMORY) ||
                                  (i_req.op == panel_bus_pkg::OP_WRITE_DATA);
          next_ctl.sel_n = 1'b0;
          // Only writes drive the bus; reads leave it to the panel.
          next_oe    = (i_req.op == panel_bus_pkg::OP_WRITE_INDEX) ||
                       (i_req.op == panel_bus_pkg::OP_WRITE_DATA);
          next_cnt   = SU;
          next_state = ST_SETUP;
        end
        else
        begin
          next_ready = 1'b1;
        end
      end
      ST_INIT:
      begin
        if (cnt <= 1)
        begin
          next_init_n = 1'b1;
          next_ready  = 1'b1;
          next_state  = ST_IDLE;
        end
        else
        begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_SETUP:
      begin
        if (cnt <= 1)
        begin
          next_ctl.store_n = !is_wr;
          next_ctl.fetch_n = !is_rd;
          next_cnt         = is_wr ? WL : RL;
          next_state       = ST_LOW;
        end
        else
        begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_LOW:
      begin
        if (cnt <= 1)
        begin
          next_ctl.store_n = 1'b1;
          next_ctl.fetch_n = 1'b1;
          if (is_rd)
          begin
            next_rd_data  = bus_in;
            next_rd_valid = 1'b1;
          end
          next_cnt   = is_wr ? WH : RH;
          next_state = ST_HIGH;
        end
        else
        begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_HIGH:
      begin
        if (cnt <= 1)
        begin
          next_ctl.sel_n = 1'b1;
          next_oe        = 1'b0;
          next_ready     = 1'b1;
          next_state     = ST_IDLE;
        end
        else
        begin
          next_cnt = cnt - 1'b1;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state                <= ST_IDLE;
      cnt                  <= '0;
      op                   <= panel_bus_pkg::OP_READ_STATUS;
      wdata                <= '0;
      o_ctl                <= '{panel_bus_pkg::RST_SEL_N, panel_bus_pkg::RST_CMD_SEL,
                                panel_bus_pkg::RST_STROBE_N, panel_bus_pkg::RST_STROBE_N};
      o_panel_bus_oe       <= 1'b0;
      o_panel_init_pulse_n <= 1'b1;
      o_req_ready          <= 1'b0;
      o_rd_valid           <= 1'b0;
      o_rd_data            <= '0;
    end
    else
    begin
      state                <= next_state;
      cnt                  <= next_cnt;
      op                   <= next_op;
      wdata                <= next_wdata;
      o_ctl                <= next_ctl;
      o_panel_bus_oe       <= next_oe;
      o_panel_init_pulse_n <= next_init_n;
      o_req_ready          <= next_ready;
      o_rd_valid           <= next_rd_valid;
      o_rd_data            <= next_rd_data;
    end
  end

  // ---------------------------------------------------------------------------
  // Bus drive, init status and supply enable
  // ---------------------------------------------------------------------------
  logic [panel_bus_pkg::BUS_W-1:0] next_bus;
  logic                            next_busy;
  logic                            next_hv;

  always_comb
  begin
    next_bus  = next_wdata;
    next_busy = (next_state == ST_INIT);
    next_hv   = i_hv_supply_req;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_panel_bus    <= '0;
      o_init_busy    <= 1'b0;
      o_hv_supply_on <= panel_bus_pkg::RST_HV;
    end
    else
    begin
      o_panel_bus    <= next_bus;
      o_init_busy    <= next_busy;
      o_hv_supply_on <= next_hv;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  logic [panel_bus_pkg::CNT_W-1:0] low_run;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      low_run <= '0;
    end
    else if (!o_ctl.store_n || !o_ctl.fetch_n || !o_panel_init_pulse_n)
    begin
      low_run <= low_run + 1'b1;
    end
    else
    begin
      low_run <= '0;
    end
  end

  a_wr_low_min: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_ctl.store_n) |-> low_run >= WL)
    else $error("store strobe low too short");

  a_rd_low_min: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_ctl.fetch_n) |-> low_run >= RL)
    else $error("fetch strobe low too short");

  a_wr_high_min: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_ctl.store_n) |-> o_ctl.store_n [*8] ##1 o_ctl.store_n [*2])
    else $error("store strobe high too short");

  a_rd_high_min: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_ctl.fetch_n) |-> o_ctl.fetch_n [*8] ##1 o_ctl.fetch_n [*8] ##1 o_ctl.fetch_n [*8]
      ##1 o_ctl.fetch_n [*6])
    else $error("fetch strobe high too short");

  a_no_both_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !(!o_ctl.store_n && !o_ctl.fetch_n))
    else $error("both strobes low");

  a_strobe_sel: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!o_ctl.store_n || !o_ctl.fetch_n) |-> !o_ctl.sel_n && $stable(o_ctl.cmd_data_sel))
    else $error("strobe without select");

  a_wr_drives: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_ctl.store_n |-> o_panel_bus_oe && $stable(o_panel_bus))
    else $error("write strobe without bus drive");

  a_rd_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!o_ctl.fetch_n || o_ctl.sel_n) |-> !o_panel_bus_oe)
    else $error("bus driven during read or idle");

  a_init_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!o_panel_init_pulse_n |-> low_run < INIT) and
    ($rose(o_panel_init_pulse_n) |-> low_run == INIT))
    else $error("init pulse not released");

  a_hv_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ##1 o_hv_supply_on == $past(i_hv_supply_req))
    else $error("supply enable does not follow request");

endmodule : panel_bus_master

`default_nettype wire

/* File: panel_bus_pkg.sv */
package panel_bus_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int WR_LOW_NS       = 50;
  localparam int WR_HIGH_NS      = 50;
  localparam int RD_LOW_NS       = 150;
  localparam int RD_HIGH_NS      = 150;
  localparam int DATA_SETUP_NS   = 25;
  localparam int INIT_LOW_NS     = 10000;
  localparam int WR_LOW_CYC      = (WR_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WR_HIGH_CYC     = (WR_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RD_LOW_CYC      = (RD_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RD_HIGH_CYC     = (RD_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETUP_CYC       = (DATA_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int INIT_LOW_CYC    = (INIT_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W           = 12;

  // ---------------------------------------------------------------------------
  // Bus fields and reset values
  // ---------------------------------------------------------------------------
  localparam int BUS_W           = 16;
  localparam logic RST_SEL_N     = 1'b1;
  localparam logic RST_STROBE_N  = 1'b1;
  localparam logic RST_CMD_SEL   = 1'b0;
  localparam logic RST_HV        = 1'b0;

  typedef enum logic [1:0]
  {
    OP_READ_STATUS,
    OP_WRITE_INDEX,
    OP_READ_MEMORY,
    OP_WRITE_DATA
  } op_t;

  typedef struct packed
  {
    op_t              op;
    logic [BUS_W-1:0] wdata;
  } req_t;

  typedef struct packed
  {
    logic sel_n;
    logic cmd_data_sel;
    logic fetch_n;
    logic store_n;
  } ctl_t;

endpackage : panel_bus_pkg

/* File: panel_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Behavioural panel controller on the far side of the bus
// ----------------------------------------------------------------
module panel_model
#(
  parameter logic [15:0] STATUS = 16'h5A3C
)
(
  input  wire logic                i_slow,
  input  wire panel_bus_pkg::ctl_t i_ctl,
  input  wire logic [15:0]         i_bus,
  input  wire logic                i_oe,
  output logic [15:0]              o_bus,
  output int                       o_errs,
  output int                       o_writes,
  output int                       o_reads
);
  logic [15:0] mem [0:15];
  logic [15:0] idx;
  logic [15:0] val;
  logic        drv;
  realtime     t_st;
  realtime     t_fe;

  // A released bus shows the inverse word, so a stale copy never passes.
  assign o_bus = drv ? val : ~val;

  initial
  begin
    for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
    idx = 16'h0000;
    val = 16'h0000;
    drv = 1'b0;
    o_errs = 0;
    o_writes = 0;
    o_reads = 0;
    t_st = 0.0;
    t_fe = 0.0;
  end

  always @(negedge i_ctl.store_n)
  begin
    if ($realtime - t_st < 50.0 || i_ctl.sel_n || !i_ctl.fetch_n || !i_oe) o_errs++;
    t_st = $realtime;
  end

  always @(posedge i_ctl.store_n)
  begin
    if (i_ctl.sel_n === 1'b0)
    begin
      if ($realtime - t_st < 50.0 || !i_oe) o_errs++;
      if (!i_ctl.cmd_data_sel) idx = i_bus;
      else mem[idx[3:0]] = i_bus;
      o_writes++;
      t_st = $realtime;
    end
  end

  always @(negedge i_ctl.fetch_n)
  begin
    if ($realtime - t_fe < 150.0 || i_ctl.sel_n || !i_ctl.store_n || i_oe) o_errs++;
    t_fe = $realtime;
    val = i_ctl.cmd_data_sel ? mem[idx[3:0]] : STATUS;
    #(i_slow ? 100.0 : 5.0);
    drv = 1'b1;
  end

  // Data is held for the read hold time after the strobe rises, then dropped.
  always @(posedge i_ctl.fetch_n)
  begin
    if (i_ctl.sel_n === 1'b0)
    begin
      if ($realtime - t_fe < 150.0) o_errs++;
      o_reads++;
      t_fe = $realtime;
      #75;
      drv = 1'b0;
    end
  end
endmodule : panel_model

`default_nettype wire

/* File: sync3.sv */
`timescale 1ns/1ps
`default_nettype none

module sync3
#(
  parameter int W = 16
)
(
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_sync;

  always_comb
  begin
    next_sync = o_sync;
    if (s2 == s3)
    begin
      next_sync = s3;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      o_sync <= '0;
    end
    else
    begin
      s1     <= i_async;
      s2     <= s1;
      s3     <= s2;
      o_sync <= next_sync;
    end
  end

endmodule : sync3

`default_nettype wire

/* File: tb_display_parallel_bus_master.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_display_parallel_bus_master;
  localparam int          INIT_CYC = 4;
  localparam logic [15:0] STATUS   = 16'h5A3C;

  logic                clk;
  logic                rst_n;
  logic                req_valid;
  panel_bus_pkg::req_t req;
  logic                init_start;
  logic                hv_req;
  logic                slow;
  logic                ready;
  logic                rd_valid;
  logic [15:0]         rd_data;
  logic                init_busy;
  logic                hv_on;
  logic                init_n;
  panel_bus_pkg::ctl_t ctl;
  logic [15:0]         bus_out;
  logic                bus_oe;
  logic [15:0]         bus_in;
  logic [15:0]         pbus;
  int                  errs;
  int                  writes;
  int                  reads;
  int                  fails;
  int                  checked;
  int                  seed;
  int                  n;
  int                  n_wr;
  int                  n_rd;
  logic [15:0]         mirror [0:15];
  logic [15:0]         idx;

  assign bus_in = bus_oe ? bus_out : pbus;

  panel_bus_master #(.INIT_CYC(INIT_CYC)) u_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_req_valid(req_valid), .i_req(req),
    .o_req_ready(ready), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
    .i_init_start(init_start), .i_hv_supply_req(hv_req), .o_init_busy(init_busy),
    .o_hv_supply_on(hv_on), .o_panel_init_pulse_n(init_n), .o_ctl(ctl),
    .o_panel_bus(bus_out), .o_panel_bus_oe(bus_oe), .i_panel_bus(bus_in));

  panel_model #(.STATUS(STATUS)) u_panel (
    .i_slow(slow), .i_ctl(ctl), .i_bus(bus_in), .i_oe(bus_oe), .o_bus(pbus),
    .o_errs(errs), .o_writes(writes), .o_reads(reads));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic wait_ready();
    n = 0;
    while (ready !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > 200)
      begin
        fails++;
        conclude();
      end
    end
  endtask : wait_ready

  function automatic logic [15:0] expect_rd(input logic [1:0] op);
    return op[1] ? mirror[idx[3:0]] : STATUS;
  endfunction : expect_rd

  // Op codes 1 and 3 are writes; 0 and 2 are reads.
  task automatic do_op(input logic [1:0] op, input logic [15:0] wd);
    wait_ready();
    req.op    = panel_bus_pkg::op_t'(op);
    req.wdata = wd;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    if (!op[0])
    begin
      n = 0;
      while (rd_valid !== 1'b1 && n < 200)
      begin
        @(negedge clk);
        n++;
      end
      if (n >= 200)
      begin
        fails++;
        conclude();
      end
      check(rd_data, expect_rd(op));
      n_rd++;
    end
    else
    begin
      if (!op[1]) idx = wd;
      else mirror[idx[3:0]] = wd;
      n_wr++;
    end
  endtask : do_op

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 34772;
    fails = 0;
    checked = 0;
    n_wr = 0;
    n_rd = 0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    init_start = 1'b0;
    hv_req = 1'b0;
    slow = 1'b0;
    idx = 16'h0000;
    for (int i = 0; i < 16; i++) mirror[i] = 16'h0000;
    repeat (20) @(negedge clk);
    check(ctl, 32'h0000000B);
    check(bus_oe, 1'b0);
    check(hv_on, 1'b0);
    rst_n = 1'b1;
    $display("test reset done");
    hv_req = 1'b1;
    repeat (2) @(negedge clk);
    check(hv_on, 1'b1);
    hv_req = 1'b0;
    repeat (2) @(negedge clk);
    check(hv_on, 1'b0);
    $display("test supply done");
    init_start = 1'b1;
    @(negedge clk);
    init_start = 1'b0;
    n = 0;
    while (init_n !== 1'b0 && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    check(init_busy, 1'b1);
    n = 0;
    while (init_n === 1'b0 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    check(n >= INIT_CYC && n <= INIT_CYC + 1, 1'b1);
    $display("test init done");
    // Boundary index and all-ones then all-zeros data, each code in turn.
    for (int k = 0; k < 8; k++) do_op(k[1:0], k < 4 ? 16'hFFFF : 16'h0000);
    $display("test corner done");
    repeat (40)
    begin
      slow = 1'($random(seed));
      do_op(2'($random(seed)), 16'($random(seed)));
    end
    wait_ready();
    repeat (20) @(negedge clk);
    check(errs, 0);
    check(writes, n_wr);
    check(reads, n_rd);
    check(ctl.sel_n, 1'b1);
    $display("test random done");
    conclude();
  end
endmodule : tb_display_parallel_bus_master

`default_nettype wire
